// *** design/dpc_pkg.sv ***
// constants and types for the dac path control register bank
//
// Summary of operation
// - bit 15 inverts the converter output sign
// - bit 14 picks third or fifth shaper
// - bit 13 mixes before or after processing
// - bit 12 enables the mixer
// - bits 11:10 pick channel 2 source
// - bits 9:8 pick channel 1 source
// - source codes; change only while mixer enabled
// - mixer off: ch1 0 dB, ch2 muted
// - bit 7 forces silence switch on
// - bit 6 enables the quiet detector
// - bits 5:4 pick zero-sample count threshold
// - bit 3 picks normal or resonant bass
// - bit 2 puts mixer in bypass
// - ratio 00: single speed, mixing allowed when mixer enabled
// - ratio 01: double speed, no mixing, volume ok
// - ratio 10: quad, no mixing/volume; 11 reserved
package dpc_pkg;

  // register map, byte addresses
  localparam logic [7:0] DPC_OFS_CTRL = 8'h14;
  localparam logic [7:0] DPC_OFS_STAT = 8'h18;
  localparam logic [15:0] DPC_CTRL_RESET = 16'h4D00;

  // control field positions
  localparam int DPC_B_SIGN = 15;
  localparam int DPC_B_SHAPER = 14;
  localparam int DPC_B_MIXPOS = 13;
  localparam int DPC_B_MIXEN = 12;
  localparam int DPC_B_RSRC = 10;
  localparam int DPC_B_LSRC = 8;
  localparam int DPC_B_FORCE = 7;
  localparam int DPC_B_QEN = 6;
  localparam int DPC_B_QTHR = 4;
  localparam int DPC_B_BASS = 3;
  localparam int DPC_B_BYPASS = 2;
  localparam int DPC_B_RATIO = 0;

  // status field positions
  localparam int DPC_S_QUIET = 0;
  localparam int DPC_S_SWITCH = 1;
  localparam int DPC_S_LSRC = 2;
  localparam int DPC_S_RSRC = 4;
  localparam int DPC_S_MIXOK = 6;
  localparam int DPC_S_VOLOK = 7;

  // source selector codes
  localparam logic [1:0] DPC_SRC_ADC = 2'h0;
  localparam logic [1:0] DPC_SRC_SERIAL = 2'h1;
  localparam logic [1:0] DPC_SRC_IEC = 2'h2;
  localparam logic [1:0] DPC_SRC_SERIAL_ALT = 2'h3;

  // input rate ratio codes
  localparam logic [1:0] DPC_RATIO_SINGLE = 2'h0;
  localparam logic [1:0] DPC_RATIO_DOUBLE = 2'h1;
  localparam logic [1:0] DPC_RATIO_QUAD = 2'h2;
  localparam logic [1:0] DPC_RATIO_RSVD = 2'h3;

  // zero-sample thresholds (3200, 4800, 9600, 19200)
  localparam int DPC_CNT_W = 15;
  localparam logic [14:0] DPC_QTHR_0 = 15'h0C80;
  localparam logic [14:0] DPC_QTHR_1 = 15'h12C0;
  localparam logic [14:0] DPC_QTHR_2 = 15'h2580;
  localparam logic [14:0] DPC_QTHR_3 = 15'h4B00;

  typedef enum logic [1:0] {
    DPC_ST_IDLE = 2'b01,
    DPC_ST_ACK = 2'b10
  } dpc_bus_state_e;

endpackage

// *** design/dpc_dac_path_control.sv ***
// dac path control register with avalon slave and quiet detector
`timescale 1ns/1ps
`default_nettype none
module dpc_dac_path_control
  import dpc_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sample stream watched by the quiet detector, and global mute for the silence switch
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic global_mute_state,
  // path controls
  output logic output_sign_flip,
  output logic shaper_order_choice,
  output logic mix_after_processing,
  output logic mixer_enable,
  output logic [1:0] left_path_source,
  output logic [1:0] right_path_source,
  output logic left_volume_force_0db,
  output logic right_volume_force_mute,
  output logic bass_resonant,
  output logic mixer_bypass,
  output logic [1:0] input_rate_ratio,
  output logic mixing_allowed,
  output logic volume_allowed,
  // silence
  output logic quiet_detected,
  output logic silence_switch
);

  dpc_bus_state_e st_r, st_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [1:0] lsrc_r, rsrc_r;
  logic [DPC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic quiet_r, quiet_nxt;

  // bus decode
  wire req = avs_read | avs_write;
  wire hit_ctrl = avs_address == DPC_OFS_CTRL;
  wire hit_stat = avs_address == DPC_OFS_STAT;
  wire commit = (st_r == DPC_ST_ACK) & req;
  wire wr_ctrl = commit & avs_write & hit_ctrl;

  always_comb begin
    case (st_r)
      DPC_ST_IDLE: st_nxt = req ? DPC_ST_ACK : DPC_ST_IDLE;
      DPC_ST_ACK: st_nxt = DPC_ST_IDLE;
      default: st_nxt = DPC_ST_IDLE;
    endcase
  end

  // byte lanes 0 and 1 carry the 16-bit register
  wire [15:0] wmerge = {avs_byteenable[1] ? avs_writedata[15:8] : ctrl_r[15:8],
                        avs_byteenable[0] ? avs_writedata[7:0] : ctrl_r[7:0]};
  // reserved ratio code keeps the previous ratio so the path never runs undefined
  wire ratio_rsvd = wmerge[DPC_B_RATIO+:2] == DPC_RATIO_RSVD;
  wire [1:0] ratio_keep = ctrl_r[DPC_B_RATIO+:2];
  assign ctrl_nxt = !wr_ctrl ? ctrl_r :
                    ratio_rsvd ? {wmerge[15:2], ratio_keep} : wmerge;

  // field views
  wire mix_en = ctrl_r[DPC_B_MIXEN];
  wire [1:0] ratio = ctrl_r[DPC_B_RATIO+:2];
  wire q_en = ctrl_r[DPC_B_QEN];
  wire [1:0] q_code = ctrl_r[DPC_B_QTHR+:2];
  wire [DPC_CNT_W-1:0] q_thr = (q_code == 2'h0) ? DPC_QTHR_0 :
                               (q_code == 2'h1) ? DPC_QTHR_1 :
                               (q_code == 2'h2) ? DPC_QTHR_2 : DPC_QTHR_3;

  // quiet detector: counts consecutive zero samples, saturates at threshold
  wire zero_smp = sample_data == '0;
  wire at_thr = cnt_r >= q_thr;
  assign cnt_nxt = !q_en ? '0 :
                   !sample_valid ? cnt_r :
                   !zero_smp ? '0 :
                   at_thr ? cnt_r : cnt_r + 1'b1;
  assign quiet_nxt = q_en & (cnt_nxt >= q_thr);

  // status word for reads
  wire [15:0] stat_word = {8'h00, volume_allowed, mixing_allowed, rsrc_r, lsrc_r,
                           silence_switch, quiet_r};
  wire [31:0] rd_word = hit_ctrl ? {16'h0000, ctrl_r} :
                        hit_stat ? {16'h0000, stat_word} : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= DPC_ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      st_r <= st_nxt;
      avs_waitrequest <= !(st_nxt == DPC_ST_ACK);
      if (st_nxt == DPC_ST_ACK) begin
        avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_r <= DPC_CTRL_RESET;
      cnt_r <= '0;
      quiet_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      quiet_r <= quiet_nxt;
    end
  end

  // applied sources only follow the register while the mixer is enabled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lsrc_r <= DPC_CTRL_RESET[DPC_B_LSRC+:2];
      rsrc_r <= DPC_CTRL_RESET[DPC_B_RSRC+:2];
    end else if (ce && mix_en) begin
      lsrc_r <= ctrl_r[DPC_B_LSRC+:2];
      rsrc_r <= ctrl_r[DPC_B_RSRC+:2];
    end
  end

  // registered path controls
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      output_sign_flip <= 1'b0;
      shaper_order_choice <= 1'b0;
      mix_after_processing <= 1'b0;
      mixer_enable <= 1'b0;
      bass_resonant <= 1'b0;
      mixer_bypass <= 1'b0;
      input_rate_ratio <= DPC_RATIO_SINGLE;
    end else if (ce) begin
      output_sign_flip <= ctrl_r[DPC_B_SIGN];
      shaper_order_choice <= ctrl_r[DPC_B_SHAPER];
      mix_after_processing <= ctrl_r[DPC_B_MIXPOS];
      mixer_enable <= mix_en;
      bass_resonant <= ctrl_r[DPC_B_BASS];
      mixer_bypass <= ctrl_r[DPC_B_BYPASS];
      input_rate_ratio <= ratio;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      // match the applied sources so no change shows after reset with the mixer off
      left_path_source <= DPC_CTRL_RESET[DPC_B_LSRC+:2];
      right_path_source <= DPC_CTRL_RESET[DPC_B_RSRC+:2];
      left_volume_force_0db <= 1'b1;
      right_volume_force_mute <= 1'b1;
      mixing_allowed <= 1'b0;
      volume_allowed <= 1'b1;
      quiet_detected <= 1'b0;
      silence_switch <= 1'b0;
    end else if (ce) begin
      left_path_source <= lsrc_r;
      right_path_source <= rsrc_r;
      left_volume_force_0db <= !mix_en;
      right_volume_force_mute <= !mix_en;
      mixing_allowed <= mix_en && (ratio == DPC_RATIO_SINGLE);
      volume_allowed <= ratio != DPC_RATIO_QUAD;
      quiet_detected <= quiet_r;
      silence_switch <= ctrl_r[DPC_B_FORCE] | quiet_r | global_mute_state;
    end
  end

endmodule
`default_nettype wire

// *** tb/dpc_dac_path_control_monitor.sv ***
// concurrent checks on the dac path control block ports
`timescale 1ns/1ps
`default_nettype none
module dpc_dac_path_control_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // path and silence
  input wire logic global_mute_state,
  input wire logic mixer_enable,
  input wire logic [1:0] left_path_source,
  input wire logic [1:0] right_path_source,
  input wire logic left_volume_force_0db,
  input wire logic right_volume_force_mute,
  input wire logic [1:0] input_rate_ratio,
  input wire logic mixing_allowed,
  input wire logic volume_allowed,
  input wire logic silence_switch
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack longer than one cycle");
  a_req_acked: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest) else $error("request not acked");
  a_mixer_off_gain: assert property (left_volume_force_0db == !mixer_enable && right_volume_force_mute == !mixer_enable)
    else $error("forced volumes do not follow mixer enable");
  a_mix_allowed: assert property (mixing_allowed == (mixer_enable && input_rate_ratio == 2'h0))
    else $error("mixing allowed wrong");
  a_volume_allowed: assert property (volume_allowed == (input_rate_ratio != 2'h2)) else $error("volume allowed wrong");
  a_ratio_legal: assert property (input_rate_ratio != 2'h3) else $error("reserved ratio applied");
  a_mute_switch: assert property ($rose(global_mute_state) |-> ##[1:3] silence_switch) else $error("mute ignored");
  a_source_hold: assert property (!mixer_enable [*3] |=> $stable(left_path_source) && $stable(right_path_source))
    else $error("source changed with mixer off");
endmodule
bind dpc_dac_path_control dpc_dac_path_control_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .global_mute_state(global_mute_state),
  .mixer_enable(mixer_enable), .left_path_source(left_path_source), .right_path_source(right_path_source),
  .left_volume_force_0db(left_volume_force_0db), .right_volume_force_mute(right_volume_force_mute),
  .input_rate_ratio(input_rate_ratio), .mixing_allowed(mixing_allowed), .volume_allowed(volume_allowed),
  .silence_switch(silence_switch));
`default_nettype wire

// *** tb/dpc_dac_path_control_test.sv ***
// self-checking bench for the dac path control block
`timescale 1ns/1ps
`default_nettype none
module dpc_dac_path_control_test;
  import dpc_pkg::*;
  logic clk_sys = 0, nrst = 0, rd = 0, wr = 0, sv = 0, gm = 0, en = 1;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0000_0000, q;
  logic [23:0] sd = 24'h00_0000;
  wire logic wrq, sf, sh, mp, me, f0, fm, bs, by, ma, va, qd, ss;
  wire logic [1:0] ls, rs, rr;
  wire logic [31:0] rdata;
  int n_errors = 0, check_count = 0;
  always #2 clk_sys = ~clk_sys;
  dpc_dac_path_control DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(en), .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdata), .avs_waitrequest(wrq),
    .sample_valid(sv), .sample_data(sd), .global_mute_state(gm), .output_sign_flip(sf), .shaper_order_choice(sh),
    .mix_after_processing(mp), .mixer_enable(me), .left_path_source(ls), .right_path_source(rs),
    .left_volume_force_0db(f0), .right_volume_force_mute(fm), .bass_resonant(bs), .mixer_bypass(by),
    .input_rate_ratio(rr), .mixing_allowed(ma), .volume_allowed(va), .quiet_detected(qd), .silence_switch(ss));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // holds the request until waitrequest is seen low, then settles outputs
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    ad <= a; wd <= {16'h0000, d}; rd <= !w; wr <= w;
    // only the watchdog ends a wait that never sees the ack
    do @(posedge clk_sys); while (wrq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task wc(input logic [15:0] v); bus(1'b1, DPC_OFS_CTRL, v); endtask
  task t_reset;
    bus(1'b0, DPC_OFS_CTRL, 16'h0000);
    chk(q, 32'h0000_4d00);
    chk({sh, f0, fm, ma, va}, 5'h1d);
  endtask
  task t_fields;
    wc(16'hb5cc);
    bus(1'b0, DPC_OFS_CTRL, 16'h0000);
    chk(q, 32'h0000_b5cc);
    chk({sf, sh, mp, me, bs, by, ss}, 7'h5f);
    chk({ls, rs, ma, f0, fm}, 7'h2c);
  endtask
  task t_src;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wc({4'h1, c, ~c, 8'h00});
      chk({ls, rs}, {~c, c});
    end
    wc(16'h0900);
    chk({ls, rs, me, f0, fm, ma}, 8'h36);
  endtask
  task t_ratio;
    wc(16'h1001);
    chk({ma, va, rr}, 4'h5);
    wc(16'h1002);
    chk({ma, va, rr}, 4'h2);
    wc(16'h1003);
    bus(1'b0, DPC_OFS_CTRL, 16'h0000);
    chk(q, 32'h0000_1002);
    bus(1'b0, 8'h20, 16'h0000);
    chk(q, 32'h0000_0000);
  endtask
  task t_quiet;
    int th[4] = '{3200, 4800, 9600, 19200};
    sd <= 24'h00_0001; sv <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      wc(16'h0040 | 16'(t << 4));
      sd <= 24'h00_0000;
      repeat (th[t] - 10) @(posedge clk_sys);
      chk(qd, 1'b0);
      repeat (20) @(posedge clk_sys);
      chk({qd, ss}, 2'h3);
      bus(1'b0, DPC_OFS_STAT, 16'h0000);
      chk(q, 32'h0000_0083);
      sd <= 24'h00_0001;
      repeat (4) @(posedge clk_sys);
      chk({qd, ss}, 2'h0);
    end
    gm <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(ss, 1'b1);
    // clock enable low must freeze the switch although mute drops
    en <= 1'b0;
    gm <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(ss, 1'b1);
    en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(ss, 1'b0);
    wc(16'h0000);
    sd <= 24'h00_0000;
    repeat (3300) @(posedge clk_sys);
    chk(qd, 1'b0);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // whole run is about 40k cycles, so 400 us leaves wide margin
  initial begin
    #400000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset; t_fields; t_src; t_ratio; t_quiet;
    test_done;
  end
endmodule
`default_nettype wire
